// *** common/tus_pkg.sv ***
/*
  tus_pkg: shared constants and types for the translation unit sideband block.
  assumes a single 25 MHz clock domain and active-low asynchronous reset.
*/
package tus_pkg;
	// channel indices into the quiescence channel arrays
	localparam int TUS_NCHAN = 2;
	localparam int TUS_CH_PWR = 0;
	localparam int TUS_CH_CG = 1;
	// default widths and depths
	localparam int TUS_DATA_W = 64;
	localparam int TUS_KEEP_W = 8;
	localparam int TUS_CNT_W = 32;
	localparam int TUS_TIE_W = 16;
	localparam int TUS_FIFO_DEPTH = 8;
	// interrupt pulse length in cycles
	localparam logic [3:0] TUS_IRQ_PULSE = 4'h2;
	// reset values
	localparam logic TUS_RST_ACK = 1'b0;
	localparam logic TUS_RST_IRQ = 1'b0;
	localparam logic TUS_RST_SYNC = 1'b0;
	// quiescence channel states
	typedef enum logic [2:0] {
		TUS_Q_RUN,
		TUS_Q_REQUEST,
		TUS_Q_STOPPED,
		TUS_Q_EXIT,
		TUS_Q_DENIED
	} tus_qstate_t;
endpackage

// *** common/tus_fifo_if.sv ***
/*
  tus_fifo_if: valid/ready carrier between the sideband top and its fifo.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface tus_fifo_if #(
	parameter int W = 8
);
	logic wr_valid;
	logic wr_ready;
	logic [W-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [W-1:0] rd_data;
	modport store (
		input wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data
	);
	modport user (
		output wr_valid, wr_data, rd_ready,
		input wr_ready, rd_valid, rd_data
	);
endinterface

// *** src/tus_fifo.sv ***
/*
  tus_fifo: flip-flop fifo with valid/ready on both sides.
  assumes DEPTH is a power of two and at least 2.
*/
`timescale 1ns/1ps
module tus_fifo
	import tus_pkg::*;
#(
	parameter int W = 8,
	parameter int DEPTH = TUS_FIFO_DEPTH
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// both sides
	tus_fifo_if.store f
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;

	assign f.wr_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign f.rd_valid = (cnt_ff != '0);
	assign f.rd_data = mem_ff[rp_ff];
	assign push = f.wr_valid & f.wr_ready;
	assign pop = f.rd_valid & f.rd_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_ff[wp_ff] <= f.wr_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wp_ff <= wp_ff + 1'b1;
			end
			if (pop) begin
				rp_ff <= rp_ff + 1'b1;
			end
			if (push && !pop) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (pop && !push) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end

	a_fifo_bound: assert property (@(posedge i_clk) disable iff (!i_nrst)
		cnt_ff <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

// *** src/tus_top.sv ***
/*
  tus_top: sideband logic of the translation buffer unit: counter snapshot
  handshake, edge interrupts, power and gating quiescence channels, tie-off
  capture and the downstream/upstream translation stream links.
  assumes snapshot request and channel requests come from other clock domains;
  event, counter and stream user signals are on i_clk.
*/
// Overview of operation
// - capture counter snapshot on request rising edge
// - raise acknowledge after snapshot is captured
// - acknowledge stays low after reset until acknowledged
// - interrupts leave as edges on two wires
// - no message-signalled interrupts, wires only
// - sample tie-offs before power channel first runs
// - stream links use valid/ready, last and keep
`timescale 1ns/1ps
module tus_top
	import tus_pkg::*;
#(
	parameter int DATA_W = TUS_DATA_W,
	parameter int KEEP_W = TUS_KEEP_W,
	parameter int CNT_W = TUS_CNT_W,
	parameter int TIE_W = TUS_TIE_W,
	parameter int DEPTH = TUS_FIFO_DEPTH
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// snapshot handshake
	input wire logic i_snap_req,
	output logic o_snap_ack,
	input wire logic [CNT_W-1:0] i_pmu_count,
	output logic [CNT_W-1:0] o_pmu_snapshot,
	// interrupt sources and wires
	input wire logic i_fault_event,
	input wire logic i_pmu_event,
	output logic o_fault_irq,
	output logic o_pmu_irq,
	// power quiescence channel
	input wire logic i_power_chan_request_n,
	output logic o_power_chan_active,
	output logic o_power_chan_accept_n,
	output logic o_power_chan_deny,
	// gating quiescence channel
	input wire logic i_gating_chan_request_n,
	output logic o_gating_chan_active,
	output logic o_gating_chan_accept_n,
	output logic o_gating_chan_deny,
	// tie-offs
	input wire logic [TIE_W-1:0] i_tieoff,
	output logic [TIE_W-1:0] o_tieoff,
	// downstream message source
	input wire logic i_msg_valid,
	output logic o_msg_ready,
	input wire logic [DATA_W-1:0] i_msg_data,
	input wire logic i_msg_last,
	input wire logic [KEEP_W-1:0] i_msg_keep,
	// downstream link
	output logic o_xlate_down_valid,
	input wire logic i_xlate_down_ready,
	output logic [DATA_W-1:0] o_xlate_down_payload,
	output logic o_xlate_down_final,
	output logic [KEEP_W-1:0] o_xlate_down_bytekeep,
	output logic o_xlate_down_wake,
	// upstream link
	input wire logic i_xlate_up_valid,
	output logic o_xlate_up_ready,
	input wire logic [DATA_W-1:0] i_xlate_up_payload,
	input wire logic i_xlate_up_final,
	input wire logic [KEEP_W-1:0] i_xlate_up_bytekeep,
	input wire logic i_xlate_up_wake,
	// upstream message sink
	output logic o_resp_valid,
	input wire logic i_resp_ready,
	output logic [DATA_W-1:0] o_resp_data,
	output logic o_resp_last,
	output logic [KEEP_W-1:0] o_resp_keep
);
	localparam int FW = DATA_W + KEEP_W + 1;

	logic [2:0] req_sync_ff;
	logic req_lvl_ff;
	logic snap_rise;
	logic ack_ff;
	logic [CNT_W-1:0] snap_ff;
	logic [1:0] ev_prev_ff;
	logic [1:0] ev_rise;
	logic [1:0] irq_ff;
	logic [3:0] irq_cnt_ff [2];
	logic [2:0] qreq_sync_ff [TUS_NCHAN];
	logic [TUS_NCHAN-1:0] qreq_lvl_ff;
	tus_qstate_t qst_ff [TUS_NCHAN];
	logic busy;
	logic pwr_run;
	logic seen_run_ff;
	logic [TIE_W-1:0] tie_ff;
	logic up_vld_ff;
	logic [FW-1:0] up_ff;

	tus_fifo_if #(.W(FW)) fq ();

	tus_fifo #(
		.W(FW),
		.DEPTH(DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.f(fq)
	);

	// snapshot request: three flops, level moves only when the last two agree
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			req_sync_ff <= {3{TUS_RST_SYNC}};
			req_lvl_ff <= TUS_RST_SYNC;
		end else begin
			req_sync_ff <= {req_sync_ff[1:0], i_snap_req};
			if (req_sync_ff[1] == req_sync_ff[2]) begin
				req_lvl_ff <= req_sync_ff[2];
			end
		end
	end
	assign snap_rise = req_sync_ff[1] & req_sync_ff[2] & ~req_lvl_ff;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			snap_ff <= '0;
		end else if (snap_rise) begin
			snap_ff <= i_pmu_count;
		end
	end

	// ack rises on the same edge as the capture, falls once the request is withdrawn
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ack_ff <= TUS_RST_ACK;
		end else if (snap_rise) begin
			ack_ff <= 1'b1;
		end else if (!req_lvl_ff) begin
			ack_ff <= 1'b0;
		end
	end
	assign o_snap_ack = ack_ff;
	assign o_pmu_snapshot = snap_ff;

	// interrupts: rising source makes a short pulse; only an event after the pulse ends is a fresh edge
	// wires only; there is no message write path at all
	assign ev_rise = {i_pmu_event, i_fault_event} & ~ev_prev_ff;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ev_prev_ff <= '0;
			irq_ff <= {2{TUS_RST_IRQ}};
			irq_cnt_ff[0] <= '0;
			irq_cnt_ff[1] <= '0;
		end else begin
			ev_prev_ff <= {i_pmu_event, i_fault_event};
			for (int i = 0; i < 2; i++) begin
				if (irq_cnt_ff[i] != '0) begin
					irq_cnt_ff[i] <= irq_cnt_ff[i] - 1'b1;
					irq_ff[i] <= (irq_cnt_ff[i] != 4'h1);
				end else if (ev_rise[i]) begin
					irq_cnt_ff[i] <= TUS_IRQ_PULSE;
					irq_ff[i] <= 1'b1;
				end
			end
		end
	end
	// an event inside a running pulse merges with it; the controller sees one edge
	assign o_fault_irq = irq_ff[0];
	assign o_pmu_irq = irq_ff[1];

	// quiescence channels; reset leaves both stopped with accept low
	assign busy = fq.rd_valid | i_msg_valid | up_vld_ff | ack_ff | req_lvl_ff;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int c = 0; c < TUS_NCHAN; c++) begin
				qreq_sync_ff[c] <= {3{TUS_RST_SYNC}};
				qst_ff[c] <= TUS_Q_STOPPED;
			end
			qreq_lvl_ff <= '0;
		end else begin
			qreq_sync_ff[TUS_CH_PWR] <= {qreq_sync_ff[TUS_CH_PWR][1:0], i_power_chan_request_n};
			qreq_sync_ff[TUS_CH_CG] <= {qreq_sync_ff[TUS_CH_CG][1:0], i_gating_chan_request_n};
			for (int c = 0; c < TUS_NCHAN; c++) begin
				if (qreq_sync_ff[c][1] == qreq_sync_ff[c][2]) begin
					qreq_lvl_ff[c] <= qreq_sync_ff[c][2];
				end
				unique case (qst_ff[c])
					TUS_Q_RUN: begin
						if (!qreq_lvl_ff[c]) begin
							qst_ff[c] <= TUS_Q_REQUEST;
						end
					end
					TUS_Q_REQUEST: begin
						qst_ff[c] <= busy ? TUS_Q_DENIED : TUS_Q_STOPPED;
					end
					TUS_Q_STOPPED: begin
						if (qreq_lvl_ff[c]) begin
							qst_ff[c] <= TUS_Q_EXIT;
						end
					end
					TUS_Q_EXIT: begin
						qst_ff[c] <= TUS_Q_RUN;
					end
					TUS_Q_DENIED: begin
						if (qreq_lvl_ff[c]) begin
							qst_ff[c] <= TUS_Q_RUN;
						end
					end
				endcase
			end
		end
	end
	assign pwr_run = (qst_ff[TUS_CH_PWR] == TUS_Q_RUN);
	assign o_power_chan_active = busy | i_xlate_up_wake;
	assign o_power_chan_accept_n = (qst_ff[TUS_CH_PWR] inside {TUS_Q_RUN, TUS_Q_REQUEST, TUS_Q_DENIED});
	assign o_power_chan_deny = (qst_ff[TUS_CH_PWR] == TUS_Q_DENIED);
	assign o_gating_chan_active = busy | i_xlate_up_wake;
	assign o_gating_chan_accept_n = (qst_ff[TUS_CH_CG] inside {TUS_Q_RUN, TUS_Q_REQUEST, TUS_Q_DENIED});
	assign o_gating_chan_deny = (qst_ff[TUS_CH_CG] == TUS_Q_DENIED);

	// tie-offs track the pins until the power channel first reaches run, then freeze
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			seen_run_ff <= 1'b0;
			tie_ff <= '0;
		end else begin
			if (pwr_run) begin
				seen_run_ff <= 1'b1;
			end
			if (!seen_run_ff && !pwr_run) begin
				tie_ff <= i_tieoff;
			end
		end
	end
	assign o_tieoff = tie_ff;

	// downstream: fifo between source and link, filled only while powered
	assign fq.wr_valid = i_msg_valid & pwr_run;
	assign fq.wr_data = {i_msg_last, i_msg_keep, i_msg_data};
	assign o_msg_ready = fq.wr_ready & pwr_run;
	// valid is never withdrawn; a filled fifo counts as busy, so power cannot stop
	assign fq.rd_ready = i_xlate_down_ready;
	assign o_xlate_down_valid = fq.rd_valid;
	assign {o_xlate_down_final, o_xlate_down_bytekeep, o_xlate_down_payload} = fq.rd_data;
	assign o_xlate_down_wake = fq.rd_valid | i_msg_valid;

	// upstream: one holding stage keeps sink data on flops
	assign o_xlate_up_ready = pwr_run & (~up_vld_ff | i_resp_ready);
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			up_vld_ff <= 1'b0;
			up_ff <= '0;
		end else if (o_xlate_up_ready) begin
			up_vld_ff <= i_xlate_up_valid;
			if (i_xlate_up_valid) begin
				up_ff <= {i_xlate_up_final, i_xlate_up_bytekeep, i_xlate_up_payload};
			end
		end
	end
	assign o_resp_valid = up_vld_ff;
	assign {o_resp_last, o_resp_keep, o_resp_data} = up_ff;

	a_snap_value: assert property (@(posedge i_clk) disable iff (!i_nrst)
		snap_rise |=> o_pmu_snapshot == $past(i_pmu_count)) else $error("snapshot not captured");
	a_ack_after: assert property (@(posedge i_clk) disable iff (!i_nrst)
		snap_rise |=> o_snap_ack) else $error("ack missing after capture");
	a_ack_cause: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_snap_ack) |-> $past(snap_rise)) else $error("ack without capture");
	a_ack_drop: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(!req_lvl_ff && !snap_rise && o_snap_ack) |=> !o_snap_ack) else $error("ack held");
	a_irq_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_fault_irq) |-> $past(ev_rise[0]) ##1 o_fault_irq ##1 !o_fault_irq)
		else $error("fault interrupt not a short pulse");
	a_pmu_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_pmu_irq |-> ##[1:2] !o_pmu_irq) else $error("pmu interrupt stuck high");
	a_tie_frozen: assert property (@(posedge i_clk) disable iff (!i_nrst)
		seen_run_ff |=> $stable(o_tieoff)) else $error("tie-off moved after run");
	a_down_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(o_xlate_down_valid && !i_xlate_down_ready) |=>
		(o_xlate_down_valid && $stable(o_xlate_down_payload)))
		else $error("down word withdrawn or changed while stalled");
	a_q_accept: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$fell(o_power_chan_accept_n) |-> $past(qst_ff[TUS_CH_PWR] == TUS_Q_REQUEST) && !$past(busy))
		else $error("accept while busy");
	a_q_deny: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_gating_chan_deny |-> o_gating_chan_accept_n) else $error("deny with accept");
endmodule

// *** verification/tus_xlate_model.sv ***
/*
  tus_xlate_model: far-end translation unit that sends each down word back up.
  assumes the block's clock and reset; i_stall holds the down link not ready.
*/
`timescale 1ns/1ps
module tus_xlate_model
	import tus_pkg::*;
#(
	parameter int DATA_W = TUS_DATA_W,
	parameter int KEEP_W = TUS_KEEP_W
) (
	// clock, reset, control
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_stall,
	// down link
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [DATA_W-1:0] i_payload,
	input wire logic i_final,
	input wire logic [KEEP_W-1:0] i_keep,
	// up link
	output logic o_valid,
	input wire logic i_ready,
	output logic [DATA_W-1:0] o_payload,
	output logic o_final,
	output logic [KEEP_W-1:0] o_keep,
	output logic o_wake
);
	logic held_ff;
	logic [DATA_W+KEEP_W:0] word_ff;
	// one word at a time, so a stall backs up into the block's fifo
	assign o_ready = !i_stall && !held_ff;
	assign o_valid = held_ff;
	assign o_wake = held_ff;
	// an idle link shows the inverse, never a stale copy of the word
	assign {o_final, o_keep, o_payload} = held_ff ? word_ff : ~word_ff;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			held_ff <= 1'b0;
			word_ff <= '0;
		end else if (held_ff && i_ready) begin
			held_ff <= 1'b0;
		end else if (o_ready && i_valid) begin
			held_ff <= 1'b1;
			word_ff <= {i_final, i_keep, i_payload};
		end
	end
endmodule

// *** verification/tus_top_tb_top.sv ***
/*
  tus_top_tb_top: self-checking bench for the sideband block.
  assumes the loopback model stands at the far end of both links.
*/
`timescale 1ns/1ps
module tus_top_tb_top;
	int err_total = 0;
	int comparisons = 0;
	logic i_clk = 1'b0;
	logic i_nrst;
	logic i_snap_req = 1'b0, i_fault_event = 1'b0, i_pmu_event = 1'b0, i_msg_valid = 1'b0;
	logic i_power_chan_request_n = 1'b0, i_gating_chan_request_n = 1'b0;
	logic i_msg_last = 1'b0, i_resp_ready = 1'b0, stall = 1'b0;
	logic [31:0] i_pmu_count = 32'h0;
	logic [15:0] i_tieoff = 16'h5a3c;
	logic [63:0] i_msg_data = 64'h0;
	logic [7:0] i_msg_keep = 8'h0;
	logic o_snap_ack, o_fault_irq, o_pmu_irq, o_msg_ready, o_resp_valid, o_resp_last;
	logic o_power_chan_active, o_power_chan_accept_n, o_power_chan_deny;
	logic o_gating_chan_active, o_gating_chan_accept_n, o_gating_chan_deny;
	logic o_xlate_down_valid, i_xlate_down_ready, o_xlate_down_final, o_xlate_down_wake;
	logic i_xlate_up_valid, o_xlate_up_ready, i_xlate_up_final, i_xlate_up_wake;
	logic [31:0] o_pmu_snapshot;
	logic [15:0] o_tieoff;
	logic [63:0] o_xlate_down_payload, i_xlate_up_payload, o_resp_data;
	logic [7:0] o_xlate_down_bytekeep, i_xlate_up_bytekeep, o_resp_keep;

	tus_top DUT (.*);
	tus_xlate_model far (.i_clk(i_clk), .i_nrst(i_nrst), .i_stall(stall),
		.i_valid(o_xlate_down_valid), .o_ready(i_xlate_down_ready),
		.i_payload(o_xlate_down_payload), .i_final(o_xlate_down_final),
		.i_keep(o_xlate_down_bytekeep), .o_valid(i_xlate_up_valid), .i_ready(o_xlate_up_ready),
		.o_payload(i_xlate_up_payload), .o_final(i_xlate_up_final),
		.o_keep(i_xlate_up_bytekeep), .o_wake(i_xlate_up_wake));

	task automatic finish_test();
		if (err_total == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: return o_snap_ack;
			1: return o_power_chan_accept_n;
			2: return o_gating_chan_deny;
			3: return o_gating_chan_accept_n;
			default: return o_resp_valid;
		endcase
	endfunction
	// bounded wait; a hang ends the run
	task automatic wait_on(input int w, input logic v);
		int n;
		n = 0;
		while (pick(w) !== v && n < 40) begin
			step(1);
			n++;
		end
		chk($sformatf("wait %0d", w), v, pick(w));
		if (pick(w) !== v) begin
			finish_test();
		end
	endtask
	task automatic t_power();
		i_power_chan_request_n = 1'b1;
		i_gating_chan_request_n = 1'b1;
		wait_on(1, 1'b1);
		wait_on(3, 1'b1);
		chk("tieoff", 16'h5a3c, o_tieoff);
		i_tieoff = 16'ha5c3;
		step(4);
		chk("tieoff frozen", 16'h5a3c, o_tieoff);
	endtask
	task automatic t_snap();
		for (int k = 0; k < 2; k++) begin
			i_pmu_count = k ? 32'h9abc_def0 : 32'h1234_5678;
			i_snap_req = 1'b1;
			wait_on(0, 1'b1);
			chk("snapshot", k ? 32'h9abc_def0 : 32'h1234_5678, o_pmu_snapshot);
			i_pmu_count = 32'h0;
			step(8);
			chk("snapshot held", k ? 32'h9abc_def0 : 32'h1234_5678, o_pmu_snapshot);
			i_snap_req = 1'b0;
			wait_on(0, 1'b0);
		end
	endtask
	task automatic t_irq();
		int rises;
		logic prev;
		for (int k = 0; k < 2; k++) begin
			i_fault_event = (k == 0);
			i_pmu_event = (k == 1);
			step(1);
			chk("irq first", 2'b01 << k, {o_pmu_irq, o_fault_irq});
			step(1);
			chk("irq second", 2'b01 << k, {o_pmu_irq, o_fault_irq});
			step(2);
			chk("irq level held", 2'b00, {o_pmu_irq, o_fault_irq});
			i_fault_event = 1'b0;
			i_pmu_event = 1'b0;
			step(2);
		end
		// controller view: count rising edges of the fault wire, events 4 cycles apart
		rises = 0;
		prev = 1'b0;
		for (int c = 0; c < 12; c++) begin
			i_fault_event = (c % 4 == 0);
			step(1);
			rises += (o_fault_irq === 1'b1 && prev === 1'b0);
			prev = o_fault_irq;
		end
		i_fault_event = 1'b0;
		chk("fault edges", 3, rises);
	endtask
	task automatic t_rereset();
		i_nrst = 1'b0;
		i_power_chan_request_n = 1'b0;
		i_gating_chan_request_n = 1'b0;
		step(2);
		chk("reset tieoff", 16'h0, o_tieoff);
		i_nrst = 1'b1;
		step(2);
		chk("recapture tieoff", 16'ha5c3, o_tieoff);
		chk("ack after rereset", 1'b0, o_snap_ack);
	endtask
	// fill the fifo against a stalled far end, then drain through the loopback
	task automatic t_stream();
		int n;
		n = 0;
		stall = 1'b1;
		i_msg_valid = 1'b1;
		while (o_msg_ready === 1'b1 && n < 20) begin
			i_msg_data = {8{n[7:0]}};
			i_msg_keep = 8'hff >> n[2:0];
			i_msg_last = n[0];
			step(1);
			n++;
		end
		i_msg_valid = 1'b0;
		chk("words stored", 8, n);
		chk("down valid wake", 2'b11, {o_xlate_down_valid, o_xlate_down_wake});
		chk("ready full", 2'b01, {o_msg_ready, o_xlate_up_ready});
		chk("down word", {1'b0, 8'hff, 64'h0}, {o_xlate_down_final, o_xlate_down_bytekeep,
			o_xlate_down_payload});
		stall = 1'b0;
		i_resp_ready = 1'b1;
		for (int k = 0; k < n; k++) begin
			wait_on(4, 1'b1);
			chk("resp word", {k[0], 8'hff >> k[2:0], {8{k[7:0]}}},
				{o_resp_last, o_resp_keep, o_resp_data});
			step(1);
		end
		step(4);
		chk("resp idle", 1'b0, o_resp_valid);
	endtask
	task automatic t_quiesce();
		i_snap_req = 1'b1;
		wait_on(0, 1'b1);
		i_gating_chan_request_n = 1'b0;
		wait_on(2, 1'b1);
		chk("busy gating", 2'b11, {o_gating_chan_active, o_gating_chan_accept_n});
		i_gating_chan_request_n = 1'b1;
		wait_on(2, 1'b0);
		i_snap_req = 1'b0;
		wait_on(0, 1'b0);
		step(6);
		i_power_chan_request_n = 1'b0;
		wait_on(1, 1'b0);
		chk("idle power", 2'b00, {o_power_chan_active, o_power_chan_deny});
		i_power_chan_request_n = 1'b1;
		wait_on(1, 1'b1);
	endtask

	initial begin
		forever #20 i_clk = ~i_clk;
	end
	initial begin
		i_nrst = 1'b0;
		step(6);
		chk("reset outputs", 4'b0000, {o_snap_ack, o_fault_irq, o_pmu_irq,
			o_power_chan_accept_n});
		i_nrst = 1'b1;
		step(2);
		chk("ack after reset", 1'b0, o_snap_ack);
		t_power();
		t_snap();
		t_irq();
		t_stream();
		t_quiesce();
		t_rereset();
		finish_test();
	end
endmodule
